// *** rtl/mtio_io.sv ***
// Motion task digital I/O interface of the drive
`timescale 1ns/1ps
`default_nettype none
module mtio_io (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire mtio_pkg::mtio_pins_t           pins,
    input  wire mtio_pkg::mtio_core_t           core,
    output var  mtio_pkg::mtio_cmd_t                 cmd,
    output logic                                target_reached_out,
    output logic                                sequence_progress_out,
    output logic                                following_err_out,
    output logic [mtio_pkg::NUM_POS_REG-1:0]    position_compare_out,
    output logic                                next_pending
);
    import mtio_pkg::*;

    localparam int NCTL = 7;
    logic [NCTL-1:0] raw, s1, s2, s3;
    logic [NCTL-1:0] rise, fall;
    logic [TASK_NUM_W-1:0] num1, num2;

    assign raw = {pins.following_err_clear_in, pins.next_task_start_in, pins.jog_start_in,
                  pins.task_resume_in, pins.base_unit_task_start_in, pins.base_unit_next_in,
                  pins.base_unit_resume_in};

    // Two-stage synchronisers and edge history per input
    genvar g;
    generate
        for (g = 0; g < NCTL; g++) begin : g_sync
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1[g] <= 1'b0;
                    s2[g] <= 1'b0;
                    s3[g] <= 1'b0;
                end else begin
                    s1[g] <= raw[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                end
            end
            assign rise[g] = s2[g] & ~s3[g];
            assign fall[g] = ~s2[g] & s3[g];
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            num1 <= TASK_NUM_RESET;
            num2 <= TASK_NUM_RESET;
        end else begin
            num1 <= pins.task_num;
            num2 <= num1;
        end
    end

    logic clr_r, next_r, jog_r, jog_f, res_r, bstart_r, bnext_r, bres_r;
    assign clr_r    = rise[6];
    assign next_r   = rise[5];
    assign jog_r    = rise[4];
    assign jog_f    = fall[4];
    assign res_r    = rise[3];
    assign bstart_r = rise[2];
    assign bnext_r  = rise[1];
    assign bres_r   = rise[0];

    // Next-task request held until the target is reached
    logic next_req;
    assign next_req = next_r | bnext_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            next_pending <= 1'b0;
        end else if (next_pending && core.target_in_window) begin
            next_pending <= 1'b0;
        end else if (next_req && !core.target_in_window) begin
            next_pending <= 1'b1;
        end
    end

    logic jog_running;
    always_ff @(posedge clk) begin
        if (rst) begin
            jog_running <= 1'b0;
        end else if (!core.jog_mode_sel || jog_f) begin
            jog_running <= 1'b0;
        end else if (jog_r) begin
            jog_running <= 1'b1;
        end
    end

    // Command outputs, one-cycle pulses except jog_run and the levels start_num, jog_dir_neg and jog_speed
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd <= '0;
        end else begin
            cmd.start_task  <= bstart_r;
            cmd.start_num   <= num2;
            cmd.start_next  <= (next_pending || next_req) && core.target_in_window;
            cmd.resume      <= res_r | bres_r;
            cmd.jog_run     <= core.jog_mode_sel && (jog_running || jog_r) && !jog_f;
            cmd.jog_abort   <= core.jog_mode_sel && jog_f && jog_running;
            cmd.jog_dir_neg <= core.jog_aux_speed[15];
            cmd.jog_speed   <= core.jog_aux_speed[15] ? 16'(-core.jog_aux_speed) : 16'(core.jog_aux_speed);
            cmd.warn_clear  <= clr_r && (core.following_err || core.monitor_warn);
        end
    end

    // Status outputs
    logic seq_level;
    always_ff @(posedge clk) begin
        if (rst) begin
            seq_level <= SEQ_OUT_RESET;
        end else if (core.task_started && core.sequence_active) begin
            if (core.sequence_first) begin
                seq_level <= 1'b0;
            end else begin
                seq_level <= ~seq_level;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            target_reached_out    <= 1'b0;
            sequence_progress_out <= SEQ_OUT_RESET;
            following_err_out     <= FERR_OUT_RESET;
            position_compare_out  <= '0;
        end else begin
            target_reached_out <= core.target_in_window;
            following_err_out  <= ~core.following_err;
            case (core.seq_mode)
                SEQ_MODE_TOGGLE: sequence_progress_out <= seq_level;
                SEQ_MODE_LEVEL:  sequence_progress_out <= core.target_in_window;
                SEQ_MODE_PREG0:  sequence_progress_out <= core.preg_text_cfg & core.preset_met[0];
                default:         sequence_progress_out <= seq_level;
            endcase
            position_compare_out <= core.preset_met;
            position_compare_out[0] <= core.preg_text_cfg & core.preset_met[0];
            position_compare_out[NUM_POS_REG-1] <= core.preg_text_cfg & core.preset_met[NUM_POS_REG-1];
        end
    end

    AST_TARGET: assert property (@(posedge clk) disable iff (rst)
        core.target_in_window |=> target_reached_out)
        else $error("in-position output missed window");
    AST_NEXT_WAIT: assert property (@(posedge clk) disable iff (rst)
        cmd.start_next |-> $past(core.target_in_window))
        else $error("next task launched before target");
    AST_NEXT_GO: assert property (@(posedge clk) disable iff (rst)
        (next_pending && core.target_in_window) |=> cmd.start_next)
        else $error("pending next task not launched");
    AST_BASE_NEXT: assert property (@(posedge clk) disable iff (rst)
        (bnext_r && core.target_in_window) |=> cmd.start_next)
        else $error("base-unit next input ignored");
    AST_JOG_ABORT: assert property (@(posedge clk) disable iff (rst)
        (core.jog_mode_sel && jog_f) |=> !cmd.jog_run)
        else $error("jog not aborted on falling edge");
    AST_JOG_DIR: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> cmd.jog_dir_neg == $past(core.jog_aux_speed[15]))
        else $error("jog direction not from sign");
    AST_RESUME: assert property (@(posedge clk) disable iff (rst)
        $rose(s2[3]) |=> cmd.resume)
        else $error("restart not resumed");
    AST_START: assert property (@(posedge clk) disable iff (rst)
        $rose(s2[2]) |=> (cmd.start_task && cmd.start_num == $past(num2)))
        else $error("base start wrong");
    AST_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (clr_r && core.following_err) |=> cmd.warn_clear)
        else $error("warning not cleared");
    AST_SEQ_FIRST: assert property (@(posedge clk) disable iff (rst)
        (core.task_started && core.sequence_active && core.sequence_first) |=> !seq_level)
        else $error("first sequence task not low");
    AST_SEQ_TOG: assert property (@(posedge clk) disable iff (rst)
        (core.task_started && core.sequence_active && !core.sequence_first) |=> seq_level != $past(seq_level))
        else $error("sequence output did not toggle");
    AST_PREG: assert property (@(posedge clk) disable iff (rst)
        core.preset_met[2] |=> position_compare_out[2])
        else $error("position register output low");
    AST_ONCE: assert property (@(posedge clk) disable iff (rst)
        cmd.start_next |=> !cmd.start_next)
        else $error("edge acted on twice");

    AST_SEQ_PREG0: assert property (@(posedge clk) disable iff (rst)
        (core.seq_mode == SEQ_MODE_PREG0) |=> sequence_progress_out == ($past(core.preg_text_cfg) & $past(core.preset_met[0])))
        else $error("progress output not register zero");
    AST_SEQ_LEVEL: assert property (@(posedge clk) disable iff (rst)
        (core.seq_mode == SEQ_MODE_LEVEL) |=> sequence_progress_out == $past(core.target_in_window))
        else $error("progress output not window level");
    AST_PREG_TEXT: assert property (@(posedge clk) disable iff (rst)
        !core.preg_text_cfg |=> (!position_compare_out[0] && !position_compare_out[NUM_POS_REG-1]))
        else $error("text-only register output set");
    AST_TARGET_LOW: assert property (@(posedge clk) disable iff (rst)
        !core.target_in_window |=> !target_reached_out)
        else $error("in-position output high outside window");
    AST_JOG_MODE: assert property (@(posedge clk) disable iff (rst)
        !core.jog_mode_sel |=> !cmd.jog_run)
        else $error("jog running outside jog mode");
    AST_NEXT_HOLD: assert property (@(posedge clk) disable iff (rst)
        (next_pending && !core.target_in_window) |=> (next_pending && !cmd.start_next))
        else $error("pending next task dropped or launched early");
    AST_CLEAR_NONE: assert property (@(posedge clk) disable iff (rst)
        !(core.following_err || core.monitor_warn) |=> !cmd.warn_clear)
        else $error("clear issued without warning");
    AST_BASE_RESUME: assert property (@(posedge clk) disable iff (rst)
        bres_r |=> cmd.resume)
        else $error("base-unit restart not resumed");
endmodule : mtio_io
`default_nettype wire

// *** rtl/mtio_pkg.sv ***
// Package for the motion task I/O interface: constants and carrier structs
package mtio_pkg;
    localparam int         TASK_NUM_W      = 8;
    localparam int         NUM_POS_REG     = 6;
    localparam logic [7:0] TASK_NUM_RESET  = 8'h00;
    localparam logic       SEQ_OUT_RESET   = 1'b0;
    localparam logic       FERR_OUT_RESET  = 1'b1;
    localparam logic [1:0] SEQ_MODE_TOGGLE = 2'h0;
    localparam logic [1:0] SEQ_MODE_LEVEL  = 2'h1;
    localparam logic [1:0] SEQ_MODE_PREG0  = 2'h2;

    // Inputs from the controller pins and the base unit
    typedef struct packed {
        logic [TASK_NUM_W-1:0] task_num;
        logic                  following_err_clear_in;
        logic                  next_task_start_in;
        logic                  jog_start_in;
        logic                  task_resume_in;
        logic                  base_unit_task_start_in;
        logic                  base_unit_next_in;
        logic                  base_unit_resume_in;
    } mtio_pins_t;

    // Status from the drive's motion core
    typedef struct packed {
        logic                   target_in_window;
        logic                   task_started;
        logic                   sequence_first;
        logic                   sequence_active;
        logic                   following_err;
        logic                   monitor_warn;
        logic [NUM_POS_REG-1:0] preset_met;
        logic                   jog_mode_sel;
        logic signed [15:0]     jog_aux_speed;
        logic [1:0]             seq_mode;
        logic                   preg_text_cfg;
    } mtio_core_t;

    // Commands to the motion core
    typedef struct packed {
        logic                  start_task;
        logic [TASK_NUM_W-1:0] start_num;
        logic                  start_next;
        logic                  resume;
        logic                  jog_run;
        logic                  jog_abort;
        logic                  jog_dir_neg;
        logic [15:0]           jog_speed;
        logic                  warn_clear;
    } mtio_cmd_t;
endpackage : mtio_pkg

// *** dv/mtio_core_model.sv ***
// Motion core model that answers the I/O block's commands
`timescale 1ns/1ps
`default_nettype none
module mtio_core_model #(
    parameter int MOVE = 20
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire mtio_pkg::mtio_cmd_t  cmd,
    input  wire mtio_pkg::mtio_core_t ctl,
    output var  mtio_pkg::mtio_core_t core
);
    import mtio_pkg::*;
    int   move;
    logic go;
    assign go = cmd.start_task | cmd.start_next | cmd.resume;
    always_ff @(posedge clk) begin
        if (rst) begin
            move <= 0;
        end else if (go) begin
            move <= MOVE;
        end else if (move > 0) begin
            move <= move - 1;
        end
    end
    always_comb begin
        core                  = ctl;
        core.task_started     = go;
        core.target_in_window = (move == 0);
    end
endmodule : mtio_core_model
`default_nettype wire

// *** dv/tb_mtio_io.sv ***
// Self-checking bench for the motion task I/O block
`timescale 1ns/1ps
`default_nettype none
module tb_mtio_io;
    import mtio_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    mtio_pins_t pins = '0;
    mtio_core_t ctl = '0;
    mtio_core_t core;
    mtio_cmd_t  cmd;
    logic       tgt, seq, ferr, pend;
    logic [5:0] pcmp;
    logic [7:0] num_seen;
    int         bad_count = 0;
    int         checks = 0;
    always #12.5 clk = ~clk;
    mtio_core_model u_mtio_core_model (.clk(clk), .rst(rst), .cmd(cmd), .ctl(ctl), .core(core));
    mtio_io u_mtio_io (.clk(clk), .rst(rst), .pins(pins), .core(core), .cmd(cmd), .target_reached_out(tgt),
        .sequence_progress_out(seq), .following_err_out(ferr), .position_compare_out(pcmp), .next_pending(pend));
    task automatic conclude();
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("Error %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    function automatic logic cf(int i);
        case (i)
            0: return cmd.start_task;
            1: return cmd.start_next;
            2: return cmd.resume;
            3: return cmd.jog_abort;
            default: return cmd.warn_clear;
        endcase
    endfunction : cf
    task automatic pin(int i, logic v);
        @(posedge clk);
        case (i)
            0: pins.base_unit_task_start_in <= v;
            1: pins.next_task_start_in <= v;
            2: pins.task_resume_in <= v;
            3: pins.jog_start_in <= v;
            4: pins.following_err_clear_in <= v;
            5: pins.base_unit_next_in <= v;
            default: pins.base_unit_resume_in <= v;
        endcase
    endtask : pin
    task automatic wait_cmd(int c);
        for (int k = 0; k < 40; k++) begin
            cyc(1);
            if (cf(c) === 1'b1) begin
                num_seen = cmd.start_num;
                cyc(1);
                chk("pulse", cf(c), 1'b0);
                return;
            end
        end
        bad_count++;
        conclude();
    endtask : wait_cmd
    task automatic go(int p, int c);
        pin(p, 1'b1);
        wait_cmd(c);
        pin(p, 1'b0);
        cyc(3);
    endtask : go
    task automatic t_start();
        @(posedge clk);
        pins.task_num <= 8'hae;
        ctl.sequence_active <= 1'b1;
        ctl.sequence_first <= 1'b1;
        pin(0, 1'b1);
        wait_cmd(0);
        pin(0, 1'b0);
        ctl.sequence_first <= 1'b0;
        cyc(1);
        chk("num", num_seen, 8'hae);
        chk("seq first", seq, 1'b0);
        chk("tgt move", tgt, 1'b0);
        pin(1, 1'b1);
        cyc(5);
        chk("pend", pend, 1'b1);
        chk("early next", cmd.start_next, 1'b0);
        wait_cmd(1);
        chk("pend off", pend, 1'b0);
        pin(1, 1'b0);
        ctl.sequence_active <= 1'b0;
        cyc(1);
        chk("seq toggle", seq, 1'b1);
    endtask : t_start
    task automatic t_jog();
        @(posedge clk);
        ctl.jog_mode_sel <= 1'b1;
        ctl.jog_aux_speed <= 16'hfffb;
        pin(3, 1'b1);
        cyc(5);
        chk("jog run", cmd.jog_run, 1'b1);
        chk("jog dir", cmd.jog_dir_neg, 1'b1);
        chk("jog speed", cmd.jog_speed, 16'h0005);
        pin(3, 1'b0);
        wait_cmd(3);
        chk("jog stop", cmd.jog_run, 1'b0);
    endtask : t_jog
    task automatic t_misc();
        go(2, 2);
        go(6, 2);
        go(5, 1);
        @(posedge clk);
        ctl.monitor_warn <= 1'b1;
        ctl.following_err <= 1'b1;
        go(4, 4);
        chk("ferr on", ferr, 1'b0);
        @(posedge clk);
        ctl.preset_met <= 6'h3f;
        cyc(2);
        chk("pcmp", pcmp, 6'h1e);
        @(posedge clk);
        ctl.preg_text_cfg <= 1'b1;
        cyc(2);
        chk("pcmp text", pcmp, 6'h3f);
        @(posedge clk);
        ctl.seq_mode <= SEQ_MODE_PREG0;
        cyc(2);
        chk("seq preg0", seq, 1'b1);
        @(posedge clk);
        ctl.seq_mode <= SEQ_MODE_LEVEL;
        cyc(25);
        chk("tgt idle", tgt, 1'b1);
        chk("seq level", seq, 1'b1);
        go(1, 1);
        chk("pend idle", pend, 1'b0);
        cyc(25);
        go(5, 1);
        chk("pend base", pend, 1'b0);
    endtask : t_misc
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        chk("ferr", ferr, 1'b1);
        chk("pcmp rst", pcmp, 6'h00);
        cyc(3);
        chk("tgt", tgt, 1'b1);
        t_start();
        t_jog();
        t_misc();
        conclude();
    end
endmodule : tb_mtio_io
`default_nettype wire
